// >>> hdl/pom_consts.svh
`ifndef POM_CONSTS_SVH
`define POM_CONSTS_SVH

// ==========================================================
// channel count
`define POM_NUM_CH     4

// ==========================================================
// register byte offsets
`define POM_OFS_POS0   6'h00
`define POM_OFS_POS1   6'h04
`define POM_OFS_POS2   6'h08
`define POM_OFS_POS3   6'h0C
`define POM_OFS_STAT   6'h10
`define POM_OFS_ISTAT  6'h14
`define POM_OFS_ICLR   6'h18
`define POM_OFS_IEN    6'h1C

// ==========================================================
// status register field positions
`define POM_ST_BUSY    0
`define POM_ST_ACT     4
`define POM_ST_DONE    8
`define POM_ST_ABEND   9
`define POM_ST_AVAIL   12

// ==========================================================
// interrupt bit positions
`define POM_IRQ_DONE   0
`define POM_IRQ_ABEND  1
`define POM_IRQ_ABS    2
`define POM_IRQ_IDLE   3
`define POM_IRQ_W      4

// ==========================================================
// reset values
`define POM_RST_POS    32'h0000_0000
`define POM_RST_IEN    4'h0

`endif

// >>> hdl/pom_pkg.sv
package pom_pkg;

	// ======================================================
	// register select, one-hot
	typedef enum logic [8:0] {
		POM_R_NONE  = 9'h000,
		POM_R_POS0  = 9'h001,
		POM_R_POS1  = 9'h002,
		POM_R_POS2  = 9'h004,
		POM_R_POS3  = 9'h008,
		POM_R_STAT  = 9'h010,
		POM_R_ISTAT = 9'h020,
		POM_R_ICLR  = 9'h040,
		POM_R_IEN   = 9'h080,
		POM_R_SPARE = 9'h100
	} pom_reg_t;

	// position counter word
	typedef logic signed [31:0] pom_pos_t;

endpackage : pom_pkg

// >>> hdl/pom_monitor.sv
// Local design decisions: the register addresses and the plain strobed port.
`timescale 1ns/1ps
`include "pom_consts.svh"
// Behaviour
// - forward pulse increments channel position, reverse pulse decrements it.
// - four channels, each with own 32-bit counter, upper half in high word.
// - counter is signed two's complement over full 32-bit range.
// - increment at most positive wraps to most negative, no error.
// - decrement at most negative wraps to most positive, no error.
// - counter content is not kept over power loss; reset clears it.
// - counter loads from absolute value read back from the drive.
// - completion flag set when an operation ends normally.
// - abnormal-end flag set instead when an operation fails.
// - both flags reflect only the operation just finished.
// - busy flag high while pulses go out, low once stopped.
// - active flag high while operation activated, even after pulsing.
// - active flag low whenever no operation is activated.
// - on small base units the third channel is unavailable.
module pom_monitor
	import pom_pkg::*;
(
	input  wire logic        ref_clk,
	input  wire logic        rst,
	input  wire logic [5:0]  regAddr,
	input  wire logic [31:0] regWrData,
	input  wire logic        regWrStb,
	input  wire logic        regRdStb,
	output logic      [31:0] regRdData,
	input  wire logic [3:0]  pulseStb,
	input  wire logic [3:0]  pulseFwd,
	input  wire logic [3:0]  pulseBusy,
	input  wire logic [3:0]  opActive,
	input  wire logic [3:0]  opStart,
	input  wire logic [3:0]  opEnd,
	input  wire logic        opOk,
	input  wire logic        absLoad,
	input  wire logic [1:0]  absCh,
	input  wire logic [31:0] absData,
	input  wire logic        smallBase,
	input  wire logic        adapterPair,
	output logic      [3:0]  pulsingFlag,
	output logic      [3:0]  opActiveFlag,
	output logic             doneFlag,
	output logic             abendFlag,
	output logic      [3:0]  chAvail,
	output logic             irq
);

	// ======================================================
	// address decode, shared by read and write paths
	function automatic pom_reg_t regDecode(input logic [5:0] a);
		case (a)
			`POM_OFS_POS0:  regDecode = POM_R_POS0;
			`POM_OFS_POS1:  regDecode = POM_R_POS1;
			`POM_OFS_POS2:  regDecode = POM_R_POS2;
			`POM_OFS_POS3:  regDecode = POM_R_POS3;
			`POM_OFS_STAT:  regDecode = POM_R_STAT;
			`POM_OFS_ISTAT: regDecode = POM_R_ISTAT;
			`POM_OFS_ICLR:  regDecode = POM_R_ICLR;
			`POM_OFS_IEN:   regDecode = POM_R_IEN;
			default:        regDecode = POM_R_NONE;
		endcase
	endfunction : regDecode

	// ======================================================
	// declarations
	pom_reg_t              wrSel;
	pom_reg_t              rdSel;
	logic     [1:0]        strapMeta_ff;
	logic     [1:0]        strapSync_ff;
	pom_pos_t              posCnt_ff [4];
	logic     [3:0]        posWr;
	logic     [3:0]        absHit;
	logic     [3:0]        stepEn;
	logic     [3:0]        pulsingFlag_ff;
	logic     [3:0]        opActiveFlag_ff;
	logic                  doneFlag_ff;
	logic                  abendFlag_ff;
	logic                  endAny;
	logic                  startAny;
	logic     [3:0]        intStat_ff;
	logic     [3:0]        intEn_ff;
	logic     [3:0]        intEvt;
	logic     [3:0]        intClr;
	logic     [31:0]       statWord;
	logic     [31:0]       nxt_rdData;
	logic     [31:0]       regRdData_ff;

	assign wrSel = regWrStb ? regDecode(regAddr) : POM_R_NONE;
	assign rdSel = regDecode(regAddr);

	// ======================================================
	// assertion clock and reset, shared by every check below
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (rst);

	// ======================================================
	// strap synchroniser: {adapter pair, small base}
	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			strapMeta_ff <= 2'h0;
			strapSync_ff <= 2'h0;
		end
		else
		begin
			strapMeta_ff <= {adapterPair, smallBase};
			strapSync_ff <= strapMeta_ff;
		end
	end

	// channel availability from fitted hardware
	assign chAvail[0] = 1'b1;
	assign chAvail[1] = 1'b1;
	assign chAvail[2] = ~strapSync_ff[0];
	assign chAvail[3] = strapSync_ff[1];

	// ======================================================
	// per-channel position counters
	genvar g;
	generate
		for (g = 0; g < `POM_NUM_CH; g++)
		begin : gCh
			// load, absolute load and step qualifiers
			assign posWr[g]  = wrSel[g] & chAvail[g];
			assign absHit[g] = absLoad & chAvail[g] &
				(absCh == 2'(g));
			assign stepEn[g] = pulseStb[g] & chAvail[g];

			// counter; natural wrap at both ends
			always_ff @(posedge ref_clk)
			begin
				if (rst)
					posCnt_ff[g] <= `POM_RST_POS;
				else if (posWr[g])
					posCnt_ff[g] <= regWrData;
				else if (absHit[g])
					posCnt_ff[g] <= absData;
				else if (stepEn[g] && pulseFwd[g])
					posCnt_ff[g] <= posCnt_ff[g] + 32'sh1;
				else if (stepEn[g])
					posCnt_ff[g] <= posCnt_ff[g] - 32'sh1;
			end

			// step, wrap, load and hold checks
			chk_fwd_step: assert property (
				stepEn[g] && pulseFwd[g] && !posWr[g] && !absHit[g]
				|=> posCnt_ff[g] == $past(posCnt_ff[g]) + 32'sh1)
				else $error("forward pulse did not increment");
			chk_rev_step: assert property (
				stepEn[g] && !pulseFwd[g] && !posWr[g] && !absHit[g]
				|=> posCnt_ff[g] == $past(posCnt_ff[g]) - 32'sh1)
				else $error("reverse pulse did not decrement");
			chk_max_wrap: assert property (
				stepEn[g] && pulseFwd[g] && !posWr[g] && !absHit[g]
				&& posCnt_ff[g] == 32'sh7FFF_FFFF
				|=> posCnt_ff[g] == 32'sh8000_0000)
				else $error("counter did not wrap to minimum");
			chk_min_wrap: assert property (
				stepEn[g] && !pulseFwd[g] && !posWr[g] && !absHit[g]
				&& posCnt_ff[g] == 32'sh8000_0000
				|=> posCnt_ff[g] == 32'sh7FFF_FFFF)
				else $error("counter did not wrap to maximum");
			chk_abs_load: assert property (
				absHit[g] && !posWr[g]
				|=> posCnt_ff[g] == $past(absData))
				else $error("absolute value not loaded");
			chk_idle_hold: assert property (
				!stepEn[g] && !posWr[g] && !absHit[g]
				|=> $stable(posCnt_ff[g]))
				else $error("counter moved without cause");
			chk_wr_load: assert property (
				posWr[g] |=> posCnt_ff[g] == $past(regWrData))
				else $error("register write not loaded");
		end
	endgenerate

	// ======================================================
	// busy and activation flags, masked by availability
	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			pulsingFlag_ff  <= 4'h0;
			opActiveFlag_ff <= 4'h0;
		end
		else
		begin
			pulsingFlag_ff  <= pulseBusy & chAvail;
			opActiveFlag_ff <= opActive & chAvail;
		end
	end

	assign pulsingFlag  = pulsingFlag_ff;
	assign opActiveFlag = opActiveFlag_ff;

	// ======================================================
	// completion and abnormal-end result flags
	assign endAny   = |(opEnd & chAvail);
	assign startAny = |(opStart & chAvail);

	// an end in the same cycle as a start wins
	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			doneFlag_ff  <= 1'b0;
			abendFlag_ff <= 1'b0;
		end
		else if (endAny)
		begin
			doneFlag_ff  <= opOk;
			abendFlag_ff <= ~opOk;
		end
		else if (startAny)
		begin
			doneFlag_ff  <= 1'b0;
			abendFlag_ff <= 1'b0;
		end
	end

	assign doneFlag  = doneFlag_ff;
	assign abendFlag = abendFlag_ff;

	// ======================================================
	// interrupt events, sticky status, enable
	assign intEvt[`POM_IRQ_DONE]  = endAny & opOk;
	assign intEvt[`POM_IRQ_ABEND] = endAny & ~opOk;
	assign intEvt[`POM_IRQ_ABS]   = |absHit;
	assign intEvt[`POM_IRQ_IDLE]  = |(pulsingFlag_ff &
		~(pulseBusy & chAvail));
	assign intClr = (wrSel == POM_R_ICLR) ?
		regWrData[`POM_IRQ_W-1:0] : 4'h0;

	// set wins over a clear in the same cycle
	always_ff @(posedge ref_clk)
	begin
		if (rst)
			intStat_ff <= 4'h0;
		else
			intStat_ff <= (intStat_ff & ~intClr) | intEvt;
	end

	always_ff @(posedge ref_clk)
	begin
		if (rst)
			intEn_ff <= `POM_RST_IEN;
		else if (wrSel == POM_R_IEN)
			intEn_ff <= regWrData[`POM_IRQ_W-1:0];
	end

	assign irq = |(intStat_ff & intEn_ff);

	// ======================================================
	// read path: data valid only in the cycle after the strobe
	always_comb
	begin
		statWord = 32'h0000_0000;
		statWord[`POM_ST_BUSY +: 4]  = pulsingFlag_ff;
		statWord[`POM_ST_ACT +: 4]   = opActiveFlag_ff;
		statWord[`POM_ST_DONE]       = doneFlag_ff;
		statWord[`POM_ST_ABEND]      = abendFlag_ff;
		statWord[`POM_ST_AVAIL +: 4] = chAvail;
	end

	always_comb
	begin
		nxt_rdData = 32'h0000_0000;
		case (rdSel)
			POM_R_POS0:  nxt_rdData = posCnt_ff[0];
			POM_R_POS1:  nxt_rdData = posCnt_ff[1];
			POM_R_POS2:  nxt_rdData = chAvail[2] ?
				posCnt_ff[2] : 32'h0000_0000;
			POM_R_POS3:  nxt_rdData = chAvail[3] ?
				posCnt_ff[3] : 32'h0000_0000;
			POM_R_STAT:  nxt_rdData = statWord;
			POM_R_ISTAT: nxt_rdData = {28'h0, intStat_ff};
			POM_R_IEN:   nxt_rdData = {28'h0, intEn_ff};
			default:     nxt_rdData = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge ref_clk)
	begin
		if (rst)
			regRdData_ff <= 32'h0000_0000;
		else if (regRdStb)
			regRdData_ff <= nxt_rdData;
		else
			regRdData_ff <= 32'h0000_0000;
	end

	assign regRdData = regRdData_ff;

	// ======================================================
	// checks on the shared logic
	chk_result_excl: assert property (
		!(doneFlag_ff && abendFlag_ff))
		else $error("done and abnormal end both set");
	chk_done_set: assert property (
		endAny && opOk |=> doneFlag_ff && !abendFlag_ff)
		else $error("normal end did not set done");
	chk_abend_set: assert property (
		endAny && !opOk |=> abendFlag_ff && !doneFlag_ff)
		else $error("failed end did not set abnormal end");
	chk_start_clear: assert property (
		startAny && !endAny |=> !doneFlag_ff && !abendFlag_ff)
		else $error("result flags not cleared at start");
	chk_result_hold: assert property (
		!startAny && !endAny |=>
		$stable(doneFlag_ff) && $stable(abendFlag_ff))
		else $error("result flags changed between ends");
	chk_busy_track: assert property (
		##1 pulsingFlag_ff == ($past(pulseBusy) & $past(chAvail)))
		else $error("busy flag does not follow pulsing");
	chk_act_low: assert property (
		!opActive[0] |=> !opActiveFlag_ff[0] [*1])
		else $error("active flag high without activation");
	chk_act_stay: assert property (
		opActive[0] && !pulseBusy[0] |=> opActiveFlag_ff[0])
		else $error("active flag dropped after pulsing");
	chk_ch3_inert: assert property (
		!chAvail[3] |=> !pulsingFlag_ff[3] && !opActiveFlag_ff[3])
		else $error("fourth channel active without adapters");
	chk_ch2_inert: assert property (
		!chAvail[2] && pulseStb[2] |=> $stable(posCnt_ff[2]))
		else $error("third channel counted on small base");
	chk_rd_window: assert property (
		regRdStb ##1 !regRdStb |=> regRdData_ff == 32'h0)
		else $error("read data stood too long");
	chk_irq_sticky: assert property (
		intEvt[`POM_IRQ_DONE] |=> intStat_ff[`POM_IRQ_DONE])
		else $error("done event lost in status");

	// ======================================================
	// register bus and interrupt checks
	chk_rd_pos: assert property (
		regRdStb && rdSel == POM_R_POS0
		|=> regRdData_ff == $past(posCnt_ff[0]))
		else $error("position read returned wrong word");
	chk_rd_idle: assert property (
		!regRdStb |=> regRdData_ff == 32'h0000_0000)
		else $error("read data without a read strobe");
	chk_ien_load: assert property (
		wrSel == POM_R_IEN
		|=> intEn_ff == $past(regWrData[`POM_IRQ_W-1:0]))
		else $error("interrupt enable not written");
	chk_irq_mask: assert property (
		intEn_ff == 4'h0 |-> !irq)
		else $error("interrupt raised while all masked");
	chk_stat_clear: assert property (
		wrSel == POM_R_ICLR && regWrData[`POM_IRQ_DONE]
		&& !intEvt[`POM_IRQ_DONE] |=> !intStat_ff[`POM_IRQ_DONE])
		else $error("status bit not cleared");
	chk_abend_stat: assert property (
		intEvt[`POM_IRQ_ABEND] |=> intStat_ff[`POM_IRQ_ABEND])
		else $error("abnormal end lost in status");
	chk_abs_stat: assert property (
		(|absHit) |=> intStat_ff[`POM_IRQ_ABS])
		else $error("absolute load lost in status");
	chk_idle_stat: assert property (
		pulsingFlag_ff[0] && !pulseBusy[0]
		|=> intStat_ff[`POM_IRQ_IDLE])
		else $error("end of pulsing lost in status");

	cov_done:  cover property (endAny && opOk ##1 doneFlag_ff);
	cov_idle:  cover property (intEvt[`POM_IRQ_IDLE]);
	cov_abend: cover property (endAny && !opOk ##1 abendFlag_ff);
	cov_wrap:  cover property (stepEn[0] && pulseFwd[0] &&
		posCnt_ff[0] == 32'sh7FFF_FFFF);
	cov_abs:   cover property (|absHit ##1 irq);

endmodule : pom_monitor

// >>> test/pom_drive.sv
`timescale 1ns/1ps
// ==========================================================
// drive model: counts steps of one channel, keeps absolute
module pom_drive
(
	input  wire logic        ref_clk,
	input  wire logic        rst,
	input  wire logic        stepIn,
	input  wire logic        stepFwd,
	output logic      [31:0] absPos,
	output logic             inPos
);
	logic [31:0] pos_ff;
	logic        quiet_ff;

	// step count kept by the drive itself
	always_ff @(posedge ref_clk)
	begin
		if (rst)
			pos_ff <= 32'h0;
		else if (stepIn)
			pos_ff <= stepFwd ? pos_ff + 32'h1 : pos_ff - 32'h1;
	end

	// in-position once no step arrives
	always_ff @(posedge ref_clk)
	begin
		quiet_ff <= !stepIn;
	end

	assign absPos = pos_ff;
	assign inPos  = quiet_ff;
endmodule : pom_drive

// >>> test/tb_pom_monitor.sv
`timescale 1ns/1ps
`include "pom_consts.svh"
module tb_pom_monitor import pom_pkg::*;;
	// ======================================================
	// stimulus and observed signals
	logic        ref_clk = 1'h0;
	logic        rst = 1'h1;
	logic [5:0]  regAddr = 6'h00;
	logic [31:0] regWrData = 32'h0;
	logic        regWrStb = 1'h0;
	logic        regRdStb = 1'h0;
	logic [3:0]  pulseStb = 4'h0;
	logic [3:0]  pulseFwd = 4'h0;
	logic [3:0]  pulseBusy = 4'h0;
	logic [3:0]  opActive = 4'h0;
	logic [3:0]  opStart = 4'h0;
	logic [3:0]  opEnd = 4'h0;
	logic        opOk = 1'h0;
	logic        absLoad = 1'h0;
	logic [1:0]  absCh = 2'h0;
	logic        smallBase = 1'h0;
	logic        adapterPair = 1'h1;
	wire  [31:0] regRdData;
	wire  [31:0] absPos;
	wire  [3:0]  pulsingFlag;
	wire  [3:0]  opActiveFlag;
	wire  [3:0]  chAvail;
	wire         doneFlag;
	wire         abendFlag;
	wire         irq;
	wire         inPos;
	logic [31:0] rv;
	int          n_mismatch = 0;
	int          comparisons = 0;

	// 250 MHz clock
	always #2 ref_clk = ~ref_clk;

	pom_monitor pom_monitor_inst (.ref_clk(ref_clk), .rst(rst),
		.regAddr(regAddr), .regWrData(regWrData), .regWrStb(regWrStb),
		.regRdStb(regRdStb), .regRdData(regRdData), .pulseStb(pulseStb),
		.pulseFwd(pulseFwd), .pulseBusy(pulseBusy), .opActive(opActive),
		.opStart(opStart), .opEnd(opEnd), .opOk(opOk), .absLoad(absLoad),
		.absCh(absCh), .absData(absPos), .smallBase(smallBase),
		.adapterPair(adapterPair), .pulsingFlag(pulsingFlag),
		.opActiveFlag(opActiveFlag), .doneFlag(doneFlag),
		.abendFlag(abendFlag), .chAvail(chAvail), .irq(irq));

	pom_drive pom_drive_inst (.ref_clk(ref_clk), .rst(rst),
		.stepIn(pulseStb[0]), .stepFwd(pulseFwd[0]), .absPos(absPos),
		.inPos(inPos));

	// ======================================================
	// shared tasks
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("BAD %0t seen %h want %h", $time, seen, exp);
		end
	endtask : chk

	task wr(input logic [5:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		regAddr <= a;
		regWrData <= d;
		regWrStb <= 1'h1;
		@(posedge ref_clk);
		regWrStb <= 1'h0;
		#1;
	endtask : wr

	task rd(input logic [5:0] a);
		@(posedge ref_clk);
		regAddr <= a;
		regRdStb <= 1'h1;
		@(posedge ref_clk);
		regRdStb <= 1'h0;
		#1 rv = regRdData;
	endtask : rd

	task step(input int ch, input logic fwd, input int n);
		repeat (n)
		begin
			@(posedge ref_clk);
			pulseStb[ch] <= 1'h1;
			pulseFwd[ch] <= fwd;
		end
		@(posedge ref_clk);
		pulseStb <= 4'h0;
	endtask : step

	task ev(input logic isEnd, input logic ok);
		if (!isEnd)
		begin
			@(posedge ref_clk);
			opActive[0] <= 1'h0;
			repeat (2) @(posedge ref_clk);
			#1 chk(opActiveFlag[0], 32'h0);
		end
		@(posedge ref_clk);
		opEnd[0] <= isEnd;
		opStart[0] <= !isEnd;
		opActive[0] <= 1'h1;
		opOk <= ok;
		@(posedge ref_clk);
		opEnd <= 4'h0;
		opStart <= 4'h0;
		#1;
	endtask : ev

	// ======================================================
	// scenarios
	task t_reset;
		rd(`POM_OFS_POS0);
		chk(rv, `POM_RST_POS);
		chk({irq, doneFlag, abendFlag}, 32'h0);
		$display("reset test done");
	endtask : t_reset

	task t_count;
		step(0, 1'h1, 3);
		step(0, 1'h0, 1);
		rd(`POM_OFS_POS0);
		chk(rv, 32'h2);
		chk(inPos, 32'h1);
		wr(`POM_OFS_POS1, 32'h0000FFFF);
		step(1, 1'h1, 1);
		rd(`POM_OFS_POS1);
		chk(rv, 32'h00010000);
		$display("count test done");
	endtask : t_count

	task t_wrap;
		wr(`POM_OFS_POS1, 32'h7FFFFFFF);
		step(1, 1'h1, 1);
		rd(`POM_OFS_POS1);
		chk(rv, 32'h80000000);
		step(1, 1'h0, 2);
		rd(`POM_OFS_POS1);
		chk(rv, 32'h7FFFFFFE);
		chk(abendFlag, 32'h0);
		$display("wrap test done");
	endtask : t_wrap

	task t_abs;
		wr(`POM_OFS_POS0, 32'h00000055);
		@(posedge ref_clk);
		absLoad <= 1'h1;
		absCh <= 2'h0;
		@(posedge ref_clk);
		absLoad <= 1'h0;
		rd(`POM_OFS_POS0);
		chk(rv, 32'h2);
		rd(`POM_OFS_ISTAT);
		chk(rv[`POM_IRQ_ABS], 32'h1);
		$display("absolute load test done");
	endtask : t_abs

	task t_ops;
		wr(`POM_OFS_IEN, 32'h1);
		@(posedge ref_clk);
		pulseBusy <= 4'h1;
		ev(1'h0, 1'h1);
		ev(1'h1, 1'h1);
		chk({doneFlag, abendFlag, irq}, 32'h5);
		chk(opActiveFlag, 32'h1);
		chk(pulsingFlag, 32'h1);
		ev(1'h0, 1'h0);
		chk({doneFlag, abendFlag}, 32'h0);
		ev(1'h1, 1'h0);
		chk({doneFlag, abendFlag}, 32'h1);
		rd(`POM_OFS_STAT);
		chk(rv[9:8], 32'h2);
		wr(`POM_OFS_ICLR, 32'hF);
		chk(irq, 32'h0);
		wr(`POM_OFS_IEN, 32'h0);
		ev(1'h0, 1'h0);
		ev(1'h1, 1'h1);
		chk(irq, 32'h0);
		rd(`POM_OFS_ISTAT);
		chk(rv[`POM_IRQ_DONE], 32'h1);
		@(posedge ref_clk);
		pulseBusy <= 4'h0;
		repeat (2) @(posedge ref_clk);
		#1 chk(pulsingFlag, 32'h0);
		chk(opActiveFlag, 32'h1);
		rd(`POM_OFS_ISTAT);
		chk(rv[`POM_IRQ_IDLE], 32'h1);
		@(posedge ref_clk);
		opActive <= 4'h0;
		repeat (2) @(posedge ref_clk);
		#1 chk(opActiveFlag, 32'h0);
		$display("operation test done");
	endtask : t_ops

	task t_avail;
		@(posedge ref_clk);
		smallBase <= 1'h1;
		adapterPair <= 1'h0;
		pulseBusy <= 4'hF;
		repeat (5) @(posedge ref_clk);
		#1 chk(chAvail, 32'h3);
		chk(pulsingFlag, 32'h3);
		wr(`POM_OFS_POS2, 32'h11);
		step(2, 1'h1, 1);
		rd(`POM_OFS_POS2);
		chk(rv, 32'h0);
		rd(6'h3C);
		chk(rv, 32'h0);
		rd(`POM_OFS_STAT);
		chk(rv[15:12], 32'h3);
		$display("availability test done");
	endtask : t_avail

	// ======================================================
	// verdict
	task results;
		$display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : results

	// main sequence
	initial
	begin
		repeat (10) @(posedge ref_clk);
		rst <= 1'h0;
		t_reset();
		t_count();
		t_wrap();
		t_abs();
		t_ops();
		t_avail();
		results();
	end

	// hang guard
	initial
	begin
		repeat (20000) @(posedge ref_clk);
		n_mismatch++;
		results();
	end
endmodule : tb_pom_monitor
